// file: rtl/kst_timing_config.sv
// Keypad scan timing and matrix size registers with settle and debounce sequencing
//
// How it works
// RULE1 - Decode registers only at addresses 0x01-0x09
// RULE2 - Wait settle interval, then start scanning
// RULE3 - Settle applied on keypad wake-up when enabled
// RULE4 - Settle applied on halt-to-operational write when enabled
// RULE5 - Settle value decodes to 16/12/8/4/0 ms
// RULE6 - Debounce spans first detection to final sample
// RULE7 - Debounce uses same decode; zero disables
// RULE8 - Row field sets rows; zero frees rows
// RULE9 - Rows 2-8 legal; value 1 is undefined
// RULE10 - Column field sets columns; zero frees columns
// RULE11 - Columns 2-12 legal; both fields reset 2
// RULE12 - Intervals counted in oscillator ticks
`timescale 1ns/10ps
module kst_timing_config
   import kst_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_hit_o,
   input wire logic scan_enable_bit_i,
   input wire logic halt_exit_i,
   input wire logic wakeup_i,
   input wire logic key_detect_i,
   output logic scan_active_o,
   output logic settling_o,
   output logic key_sample_o,
   output logic [3:0] row_count_o,
   output logic [3:0] col_count_o,
   output logic [7:0] row_line_keypad_o,
   output logic [11:0] column_line_keypad_o,
   output logic row_dedicated_o,
   output logic column_dedicated_o
);
   logic [7:0] settle_q;
   logic [7:0] settle_d;
   logic [7:0] bounce_q;
   logic [7:0] bounce_d;
   logic [7:0] size_q;
   logic [7:0] size_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic hit_q;
   logic hit_d;
   logic [15:0] div_q;
   logic [15:0] div_d;
   logic tick_q;
   logic tick_d;
   kst_state_t state_q;
   kst_state_t state_d;
   logic sample_q;
   logic sample_d;
   logic [7:0] rows_mask_q;
   logic [7:0] rows_mask_d;
   logic [11:0] cols_mask_q;
   logic [11:0] cols_mask_d;
   logic scan_q;
   logic scan_d;
   logic settle_flag_q;
   logic settle_flag_d;
   logic row_ded_q;
   logic row_ded_d;
   logic col_ded_q;
   logic col_ded_d;
   logic key_seen_q;
   logic key_seen_d;
   logic in_range;
   logic settle_start;
   logic settle_busy;
   logic settle_done;
   logic bounce_start;
   logic bounce_busy;
   logic bounce_done;
   logic [3:0] rows;
   logic [3:0] cols;

   function automatic logic [9:0] kst_decode(input logic [7:0] v);
      if (v[7:6] == KST_RANGE_16) begin
         kst_decode = KST_TICKS_16; // RULE5
      end else if (v[7:6] == KST_RANGE_12) begin
         kst_decode = KST_TICKS_12;
      end else if (v[7:6] == KST_RANGE_8) begin
         kst_decode = KST_TICKS_8;
      end else if (v != 8'h00) begin
         kst_decode = KST_TICKS_4;
      end else begin
         kst_decode = KST_TICKS_NONE;
      end
   endfunction : kst_decode

   assign rows = size_q[KST_ROW_HI:KST_ROW_LO];
   assign cols = size_q[KST_COL_HI:KST_COL_LO];
   assign in_range = (reg_addr_i >= KST_ADDR_LO) && (reg_addr_i <= KST_ADDR_HI); // RULE1

   // Register file
   always_comb begin
      settle_d = settle_q;
      bounce_d = bounce_q;
      size_d = size_q;
      rdata_d = rdata_q;
      hit_d = 1'b0;
      if (reg_wr_i && in_range) begin
         hit_d = 1'b1;
         unique case (reg_addr_i)
            KST_ADDR_SETTLE: settle_d = reg_wdata_i;
            KST_ADDR_BOUNCE: bounce_d = reg_wdata_i;
            KST_ADDR_SIZE: size_d = reg_wdata_i; // RULE9 RULE11
            default: ;
         endcase
      end
      if (reg_rd_i && in_range) begin
         hit_d = 1'b1;
         unique case (reg_addr_i)
            KST_ADDR_SETTLE: rdata_d = settle_q;
            KST_ADDR_BOUNCE: rdata_d = bounce_q;
            KST_ADDR_SIZE: rdata_d = size_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Oscillator tick from the system clock; a real part would use its slow oscillator
   always_comb begin
      tick_d = 1'b0;
      div_d = div_q + 16'h0001;
      if (div_q == 16'(KST_TICK_DIV - 1)) begin
         div_d = 16'h0000;
         tick_d = 1'b1; // RULE12
      end
   end

   // Scan sequencing
   // Gated by state, not by timer busy, so a settle cut short by disable cannot lock out later triggers
   assign settle_start = scan_enable_bit_i && (wakeup_i || halt_exit_i) && (state_q != KST_SETTLE); // RULE3 RULE4
   // Only the first detection starts debounce; a held key must not restart it every cycle
   assign bounce_start = (state_q == KST_SCAN) && key_detect_i && !key_seen_q && !bounce_busy && !settle_busy; // RULE6
   always_comb begin
      state_d = state_q;
      sample_d = bounce_done; // RULE6 RULE7
      key_seen_d = key_detect_i;
      if (!scan_enable_bit_i) begin
         state_d = KST_IDLE;
         sample_d = 1'b0;
      end else begin
         unique case (state_q)
            KST_IDLE: if (settle_start) state_d = KST_SETTLE;
            KST_SETTLE: if (settle_done) state_d = KST_SCAN; // RULE2
            KST_SCAN: if (settle_start) state_d = KST_SETTLE;
            default: state_d = KST_IDLE;
         endcase
      end
      scan_d = (state_d == KST_SCAN);
      settle_flag_d = (state_d == KST_SETTLE);
      row_ded_d = (size_d[KST_ROW_HI:KST_ROW_LO] == KST_SIZE_FREE) && (state_d != KST_IDLE); // RULE8
      col_ded_d = (size_d[KST_COL_HI:KST_COL_LO] == KST_SIZE_FREE) && (state_d != KST_IDLE); // RULE10
   end

   // Line assignment from matrix size; lines below the count become keypad lines, zero or 1 gives no keypad lines, only zero marks them dedicated
   always_comb begin
      rows_mask_d = 8'h00;
      cols_mask_d = 12'h000;
      for (int i = 0; i < KST_ROW_LINES; i++) begin
         rows_mask_d[i] = (4'(i) < rows) && (rows != KST_SIZE_ILLEGAL); // RULE8 RULE9
      end
      for (int j = 0; j < KST_COL_LINES; j++) begin
         cols_mask_d[j] = (4'(j) < cols) && (cols != KST_SIZE_ILLEGAL); // RULE10 RULE11
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         settle_q <= KST_SETTLE_RST;
         bounce_q <= KST_BOUNCE_RST;
         size_q <= {KST_ROWS_RST, KST_COLS_RST}; // RULE11
         rdata_q <= 8'h00;
         hit_q <= 1'b0;
         div_q <= 16'h0000;
         tick_q <= 1'b0;
         state_q <= KST_IDLE;
         sample_q <= 1'b0;
         rows_mask_q <= 8'h00;
         cols_mask_q <= 12'h000;
         scan_q <= 1'b0;
         settle_flag_q <= 1'b0;
         row_ded_q <= 1'b0;
         col_ded_q <= 1'b0;
         key_seen_q <= 1'b0;
      end else begin
         settle_q <= settle_d;
         bounce_q <= bounce_d;
         size_q <= size_d;
         rdata_q <= rdata_d;
         hit_q <= hit_d;
         div_q <= div_d;
         tick_q <= tick_d;
         state_q <= state_d;
         sample_q <= sample_d;
         rows_mask_q <= rows_mask_d;
         cols_mask_q <= cols_mask_d;
         scan_q <= scan_d;
         settle_flag_q <= settle_flag_d;
         row_ded_q <= row_ded_d;
         col_ded_q <= col_ded_d;
         key_seen_q <= key_seen_d;
      end
   end

   kst_interval_timer u_settle (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .tick_i(tick_q),
      .start_i(settle_start),
      .ticks_i(kst_decode(settle_q)), // RULE5
      .busy_o(settle_busy),
      .done_o(settle_done)
   );

   kst_interval_timer u_bounce (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .tick_i(tick_q),
      .start_i(bounce_start),
      .ticks_i(kst_decode(bounce_q)), // RULE7
      .busy_o(bounce_busy),
      .done_o(bounce_done)
   );

   assign reg_rdata_o = rdata_q;
   assign reg_hit_o = hit_q;
   assign scan_active_o = scan_q;
   assign settling_o = settle_flag_q;
   assign key_sample_o = sample_q;
   assign row_count_o = size_q[KST_ROW_HI:KST_ROW_LO];
   assign col_count_o = size_q[KST_COL_HI:KST_COL_LO];
   assign row_line_keypad_o = rows_mask_q;
   assign column_line_keypad_o = cols_mask_q;
   assign row_dedicated_o = row_ded_q; // RULE8
   assign column_dedicated_o = col_ded_q; // RULE10
endmodule : kst_timing_config

// file: rtl/kst_pkg.sv
// Package with register map, field layout and timing constants of the keypad timing block
package kst_pkg;
   localparam logic [7:0] KST_ADDR_LO = 8'h01;
   localparam logic [7:0] KST_ADDR_HI = 8'h09;
   localparam logic [7:0] KST_ADDR_SETTLE = 8'h01;
   localparam logic [7:0] KST_ADDR_BOUNCE = 8'h02;
   localparam logic [7:0] KST_ADDR_SIZE = 8'h03;
   localparam logic [7:0] KST_SETTLE_RST = 8'h80;
   localparam logic [7:0] KST_BOUNCE_RST = 8'h80;
   localparam logic [3:0] KST_ROWS_RST = 4'h2;
   localparam logic [3:0] KST_COLS_RST = 4'h2;
   localparam logic [3:0] KST_ROWS_MAX = 4'h8;
   localparam logic [3:0] KST_COLS_MAX = 4'hc;
   localparam logic [3:0] KST_SIZE_FREE = 4'h0;
   localparam logic [3:0] KST_SIZE_ILLEGAL = 4'h1;
   localparam int KST_ROW_HI = 7;
   localparam int KST_ROW_LO = 4;
   localparam int KST_COL_HI = 3;
   localparam int KST_COL_LO = 0;
   localparam int KST_ROW_LINES = 8;
   localparam int KST_COL_LINES = 12;
   localparam logic [7:0] KST_DED_MASK = 8'h03;
   // Time targets in ms and the oscillator tick rate
   localparam int KST_CLK_HZ = 25000000;
   localparam int KST_TICK_HZ = 32768;
   localparam int KST_MS_16 = 16;
   localparam int KST_MS_12 = 12;
   localparam int KST_MS_8 = 8;
   localparam int KST_MS_4 = 4;
   // System clocks per oscillator tick, rounded down
   localparam int KST_TICK_DIV = KST_CLK_HZ / KST_TICK_HZ;
   // Tick counts, rounded up so each coded range meets its target
   localparam logic [9:0] KST_TICKS_16 = 10'((KST_MS_16 * KST_TICK_HZ + 999) / 1000);
   localparam logic [9:0] KST_TICKS_12 = 10'((KST_MS_12 * KST_TICK_HZ + 999) / 1000);
   localparam logic [9:0] KST_TICKS_8 = 10'((KST_MS_8 * KST_TICK_HZ + 999) / 1000);
   localparam logic [9:0] KST_TICKS_4 = 10'((KST_MS_4 * KST_TICK_HZ + 999) / 1000);
   localparam logic [9:0] KST_TICKS_NONE = 10'h000;
   localparam logic [1:0] KST_RANGE_16 = 2'h3;
   localparam logic [1:0] KST_RANGE_12 = 2'h2;
   localparam logic [1:0] KST_RANGE_8 = 2'h1;
   typedef enum logic [1:0] {
      KST_IDLE = 2'b00,
      KST_SETTLE = 2'b01,
      KST_SCAN = 2'b10
   } kst_state_t;
endpackage : kst_pkg

// file: rtl/kst_interval_timer.sv
// Loadable down-counter of oscillator ticks that signals when an interval has run out
`timescale 1ns/10ps
module kst_interval_timer (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic tick_i,
   input wire logic start_i,
   input wire logic [9:0] ticks_i,
   output logic busy_o,
   output logic done_o
);
   logic [9:0] cnt_q;
   logic [9:0] cnt_d;
   logic busy_q;
   logic busy_d;
   logic done_q;
   logic done_d;
   always_comb begin
      cnt_d = cnt_q;
      busy_d = busy_q;
      done_d = 1'b0;
      if (start_i) begin
         // A zero interval finishes at once
         cnt_d = ticks_i;
         busy_d = (ticks_i != 10'h000);
         done_d = (ticks_i == 10'h000);
      end else if (busy_q && tick_i) begin
         cnt_d = cnt_q - 10'h001;
         if (cnt_q == 10'h001) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end
   end
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_q <= 10'h000;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end
   assign busy_o = busy_q;
   assign done_o = done_q;
endmodule : kst_interval_timer

// file: sim/kst_key_matrix_model.sv
// Key matrix model that reports a pressed key seen through the used or dedicated columns
`timescale 1ns/10ps
module kst_key_matrix_model (
   input wire logic sys_clk_i,
   input wire logic press_i,
   input wire logic [11:0] column_line_keypad_i,
   input wire logic column_dedicated_i,
   output logic key_detect_o
);
   // A key is visible through any keypad column or while the columns are dedicated
   always_ff @(posedge sys_clk_i) begin
      key_detect_o <= press_i && (|column_line_keypad_i || column_dedicated_i);
   end
endmodule : kst_key_matrix_model

// file: sim/kst_timing_config_checker.sv
// Port assertions for the keypad timing block
`timescale 1ns/10ps
module kst_timing_config_checker (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic reg_hit_o,
   input wire logic scan_enable_bit_i,
   input wire logic halt_exit_i,
   input wire logic wakeup_i,
   input wire logic scan_active_o,
   input wire logic settling_o,
   input wire logic key_sample_o,
   input wire logic [3:0] row_count_o,
   input wire logic [3:0] col_count_o,
   input wire logic [7:0] row_line_keypad_o,
   input wire logic [11:0] column_line_keypad_o,
   input wire logic row_dedicated_o,
   input wire logic column_dedicated_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   function automatic logic [11:0] lines(input logic [3:0] n);
      return (n == 4'h1) ? 12'h000 : 12'((13'h1 << n) - 13'h1);
   endfunction : lines
   sequence s_in;
      (reg_wr_i || reg_rd_i) && reg_addr_i >= 8'h01 && reg_addr_i <= 8'h09;
   endsequence
   sequence s_out;
      !(reg_wr_i || reg_rd_i) || reg_addr_i < 8'h01 || reg_addr_i > 8'h09;
   endsequence
   sequence s_trig;
      (wakeup_i || halt_exit_i) && scan_enable_bit_i && !settling_o && !scan_active_o;
   endsequence
   a_hit_in: assert property (s_in |=> reg_hit_o) else $error("hit missing");
   a_hit_out: assert property (s_out |=> !reg_hit_o) else $error("stray hit");
   a_idle_off: assert property (!scan_enable_bit_i [*2] |-> !scan_active_o && !settling_o)
      else $error("busy while disabled");
   a_scan_enabled: assert property ($rose(scan_active_o) |-> $past(scan_enable_bit_i))
      else $error("scan without enable");
   a_settle_trig: assert property (s_trig |-> ##[1:3] (settling_o || scan_active_o || !scan_enable_bit_i))
      else $error("trigger ignored");
   a_sample_pulse: assert property (key_sample_o |=> !key_sample_o) else $error("long sample");
   a_row_ded: assert property (row_dedicated_o |-> row_count_o == 4'h0) else $error("row ded");
   a_col_ded: assert property (column_dedicated_o |-> col_count_o == 4'h0) else $error("col ded");
   a_row_mask: assert property ($past(reset_n_i) |-> row_line_keypad_o == 8'(lines($past(row_count_o))))
      else $error("row mask");
   a_col_mask: assert property ($past(reset_n_i) |-> column_line_keypad_o == lines($past(col_count_o)))
      else $error("col mask");
endmodule : kst_timing_config_checker
bind kst_timing_config kst_timing_config_checker kst_timing_config_checker_inst (.sys_clk_i, .reset_n_i,
   .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_hit_o, .scan_enable_bit_i, .halt_exit_i, .wakeup_i, .scan_active_o,
   .settling_o, .key_sample_o, .row_count_o, .col_count_o, .row_line_keypad_o, .column_line_keypad_o,
   .row_dedicated_o, .column_dedicated_o);

// file: sim/kst_timing_config_bench.sv
// Self-checking bench for the keypad timing and size registers
`timescale 1ns/10ps
module kst_timing_config_bench;
   import kst_pkg::*;
   logic sys_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic scan_enable_bit_i = 1'b0;
   logic halt_exit_i = 1'b0;
   logic wakeup_i = 1'b0;
   logic press = 1'b0;
   logic key_detect_i, reg_hit_o, scan_active_o, settling_o, key_sample_o, row_dedicated_o, column_dedicated_o;
   logic [7:0] reg_rdata_o, row_line_keypad_o;
   logic [3:0] row_count_o, col_count_o;
   logic [11:0] column_line_keypad_o;
   logic [7:0] adr [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h09, 8'h0a};
   logic [7:0] val [6] = '{8'h00, 8'h80, 8'h80, 8'h22, 8'h00, 8'h00};
   logic [7:0] sz [3] = '{8'h8c, 8'h25, 8'h00};
   int num_errors = 0;
   int cmp_count = 0;
   int s;
   always #20 sys_clk_i = ~sys_clk_i;
   kst_timing_config kst_timing_config_inst (.sys_clk_i, .reset_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
      .reg_wdata_i, .reg_rdata_o, .reg_hit_o, .scan_enable_bit_i, .halt_exit_i, .wakeup_i, .key_detect_i,
      .scan_active_o, .settling_o, .key_sample_o, .row_count_o, .col_count_o, .row_line_keypad_o,
      .column_line_keypad_o, .row_dedicated_o, .column_dedicated_o);
   kst_key_matrix_model kst_key_matrix_model_inst (.sys_clk_i, .press_i(press),
      .column_line_keypad_i(column_line_keypad_o), .column_dedicated_i(column_dedicated_o),
      .key_detect_o(key_detect_i));
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= wr;
      reg_rd_i <= !wr;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      #1;
   endtask : acc
   // Counts cycles with the chosen flag high; with stop set, a wait that never sees it ends the run
   task automatic watch(input int sel, input int n, input logic stop, output int seen);
      seen = 0;
      for (int i = 0; i < n && !(stop && seen > 0); i++) begin
         @(posedge sys_clk_i);
         #1;
         seen += int'((sel == 0) ? scan_active_o === 1'b1 : key_sample_o === 1'b1);
      end
      if (stop && seen == 0) begin
         num_errors++;
         stop_test();
      end
   endtask : watch
   task automatic pulse(input logic halt);
      @(posedge sys_clk_i);
      scan_enable_bit_i <= 1'b1;
      wakeup_i <= !halt;
      halt_exit_i <= halt;
      @(posedge sys_clk_i);
      wakeup_i <= 1'b0;
      halt_exit_i <= 1'b0;
   endtask : pulse
   initial begin
      repeat (4) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      foreach (adr[i]) begin
         acc(1'b0, adr[i], 8'h00);
         chk(reg_hit_o, adr[i] >= KST_ADDR_LO && adr[i] <= KST_ADDR_HI);
         chk(reg_rdata_o, val[i]);
      end
      $display("test reset and range done");
      // Only legal sizes are written, 0x1 is never used
      foreach (sz[i]) begin
         acc(1'b1, KST_ADDR_SIZE, sz[i]);
         acc(1'b0, KST_ADDR_SIZE, 8'h00);
         chk(reg_rdata_o, sz[i]);
         chk(row_count_o, sz[i][7:4]);
         chk(col_count_o, sz[i][3:0]);
         chk(row_line_keypad_o, 8'((9'h1 << sz[i][7:4]) - 9'h1));
         chk(column_line_keypad_o, 12'((13'h1 << sz[i][3:0]) - 13'h1));
      end
      $display("test matrix size done");
      acc(1'b1, KST_ADDR_SETTLE, 8'h00);
      acc(1'b1, KST_ADDR_BOUNCE, 8'h00);
      pulse(1'b0);
      watch(0, 10, 1'b1, s);
      chk(row_dedicated_o, 1'b1);
      chk(column_dedicated_o, 1'b1);
      press <= 1'b1;
      watch(1, 20, 1'b1, s);
      @(posedge sys_clk_i);
      press <= 1'b0;
      scan_enable_bit_i <= 1'b0;
      #1;
      chk(key_sample_o, 1'b0);
      repeat (3) @(posedge sys_clk_i);
      pulse(1'b1);
      watch(0, 10, 1'b1, s);
      $display("test zero intervals done");
      acc(1'b1, KST_ADDR_BOUNCE, 8'h01);
      repeat (3) @(posedge sys_clk_i);
      press <= 1'b1;
      watch(1, 600, 1'b0, s);
      chk(12'(s), 12'h000);
      @(posedge sys_clk_i);
      press <= 1'b0;
      scan_enable_bit_i <= 1'b0;
      acc(1'b1, KST_ADDR_SETTLE, 8'hff);
      pulse(1'b0);
      watch(0, 600, 1'b0, s);
      chk(12'(s), 12'h000);
      chk(settling_o, 1'b1);
      $display("test long intervals done");
      stop_test();
   end
endmodule : kst_timing_config_bench
